// file: rtl/ccsc_pkg.sv
// Shared types, limits and checker function of the channel selector
package ccsc_pkg;
  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int CCSC_NUM_CAP = 8;      // Capture channels 0..7
  localparam int CCSC_FIFO_DEPTH = 16;  // Stream buffer depth
  localparam int CCSC_PIX_W = 16;       // Pixel word width
  // Rates below are in units of 1/8 Mbyte/s, clocks in 1/8 MHz
  localparam logic [15:0] CCSC_MAX_CAP_CLK = 16'h06f6;  // 222.75
  localparam logic [15:0] CCSC_MAX_PAR_CLK = 16'h0320;  // 100
  localparam logic [15:0] CCSC_LONE_RATE = 16'h0dec;    // 148.5 x 3
  localparam logic [22:0] CCSC_MAX_OUT = 23'h001bd8;    // 891
  localparam logic [25:0] CCSC_SUM_ONE = 26'h00029c4;   // 1336.5
  localparam logic [25:0] CCSC_SUM_TWO = 26'h000459c;   // 2227.5
  // Fault vector bit positions
  localparam int CCSC_F_RANGE = 0;  // Source on a forbidden channel
  localparam int CCSC_F_VC0 = 1;    // Virtual channel 0 misplaced
  localparam int CCSC_F_CLK = 2;    // Capture clock too fast
  localparam int CCSC_F_PAR = 3;    // Parallel port clock too fast
  localparam int CCSC_F_OUT = 4;    // Per channel output rate
  localparam int CCSC_F_LONE = 5;   // High rate quad not alone
  localparam int CCSC_F_SEL = 6;    // Highest rate stream not on 4
  localparam int CCSC_F_SUM = 7;    // Summed output rate
  localparam int CCSC_F_VAR = 8;    // Source missing in variant
  localparam int CCSC_F_W = 9;
  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CCSC_SRC_QUAD_A = 2'h0,
    CCSC_SRC_QUAD_B = 2'h1,
    CCSC_SRC_DUAL = 2'h2,
    CCSC_SRC_PAR = 2'h3
  } ccsc_src_t;
  // One capture channel's routing and rate setting
  typedef struct packed {
    logic en;
    ccsc_src_t src;
    logic [1:0] vc;
    logic [15:0] vclk;      // Video clock, 1/8 MHz
    logic [7:0] scale_q4;   // Scaling factor, 4 fraction bits
    logic [2:0] depth;      // Output bytes per pixel
    logic [15:0] in_rate;   // Input rate, 1/8 Mbyte/s
  } ccsc_entry_t;
  typedef ccsc_entry_t [CCSC_NUM_CAP-1:0] ccsc_table_t;
  // Stream word as it arrives from a receiver
  typedef struct packed {
    ccsc_src_t src;
    logic [1:0] vc;
    logic [CCSC_PIX_W-1:0] data;
  } ccsc_word_t;
  // Word delivered to a capture channel
  typedef struct packed {
    logic [2:0] chan;
    logic [CCSC_PIX_W-1:0] data;
  } ccsc_cap_t;
  // ==========================================================
  // Output rate: clock x scale x depth
  // ==========================================================
  function automatic logic [22:0] ccsc_out_rate(input ccsc_entry_t e);
    logic [26:0] p;
    p = 27'(e.vclk) * 27'(e.scale_q4) * 27'(e.depth);
    return p[26:4];
  endfunction : ccsc_out_rate
  // ==========================================================
  // Full routing and throughput check of a table
  // ==========================================================
  function automatic logic [CCSC_F_W-1:0] ccsc_check(
    input ccsc_table_t t, input logic two_quad);
    logic [CCSC_F_W-1:0] f;
    logic [25:0] sum;
    logic [22:0] r;
    logic par_used;
    logic hi_a;
    logic hi_b;
    logic cand;
    logic cand4;
    f = '0;
    sum = '0;
    par_used = 1'b0;
    hi_a = 1'b0;
    hi_b = 1'b0;
    for (int i = 0; i < CCSC_NUM_CAP; i++) begin
      if (t[i].en) begin
        r = ccsc_out_rate(t[i]);
        sum = sum + 26'(r);
        if (t[i].vclk > CCSC_MAX_CAP_CLK) f[CCSC_F_CLK] = 1'b1;
        if (r > CCSC_MAX_OUT) f[CCSC_F_OUT] = 1'b1;
        unique case (t[i].src)
          CCSC_SRC_QUAD_A: begin
            if (i > 3) f[CCSC_F_RANGE] = 1'b1;
            if (t[i].vc == 2'h0 && i != 0) f[CCSC_F_VC0] = 1'b1;
            if (t[i].in_rate > CCSC_LONE_RATE) hi_a = 1'b1;
          end
          CCSC_SRC_QUAD_B: begin
            if (!two_quad) f[CCSC_F_VAR] = 1'b1;
            if (i < 4) f[CCSC_F_RANGE] = 1'b1;
            if (t[i].vc == 2'h0 && i != 4) f[CCSC_F_VC0] = 1'b1;
            if (t[i].in_rate > CCSC_LONE_RATE) hi_b = 1'b1;
          end
          CCSC_SRC_DUAL: begin
            if (two_quad) begin
              if (t[i].vc == 2'h0 && i != 0 && i != 4)
                f[CCSC_F_VC0] = 1'b1;
            end else begin
              if (i < 4) f[CCSC_F_RANGE] = 1'b1;
              if (t[i].vc == 2'h0 && i != 4) f[CCSC_F_VC0] = 1'b1;
            end
          end
          CCSC_SRC_PAR: begin
            par_used = 1'b1;
            if (t[i].vclk > CCSC_MAX_PAR_CLK) f[CCSC_F_PAR] = 1'b1;
          end
        endcase
      end
    end
    // In the two-quad variant, parallel port in use pushes the dual receiver to 0..3
    cand4 = two_quad ? (t[4].src inside {CCSC_SRC_QUAD_B, CCSC_SRC_DUAL})
                     : (t[4].src inside {CCSC_SRC_PAR, CCSC_SRC_DUAL});
    for (int j = 0; j < CCSC_NUM_CAP; j++) begin
      if (two_quad && par_used && t[j].en && t[j].src == CCSC_SRC_DUAL
          && j > 3) f[CCSC_F_RANGE] = 1'b1;
      cand = two_quad
        ? (!par_used && t[j].src inside {CCSC_SRC_QUAD_B, CCSC_SRC_DUAL})
        : (t[j].src inside {CCSC_SRC_PAR, CCSC_SRC_DUAL});
      if (t[j].en && cand && !(t[4].en && cand4
          && t[4].in_rate >= t[j].in_rate)) f[CCSC_F_SEL] = 1'b1;
    end
    if (hi_a && (t[1].en || t[2].en || t[3].en)) f[CCSC_F_LONE] = 1'b1;
    if (hi_b && (t[5].en || t[6].en || t[7].en)) f[CCSC_F_LONE] = 1'b1;
    if (sum > (two_quad ? CCSC_SUM_TWO : CCSC_SUM_ONE))
      f[CCSC_F_SUM] = 1'b1;
    return f;
  endfunction : ccsc_check
endpackage : ccsc_pkg

// file: rtl/ccsc_fifo.sv
// Parameterised first-in first-out buffer with valid/ready sides
module ccsc_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // Parameter check
  // ==========================================================
  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
    $error("ccsc_fifo: depth must be a power of two of at least 2");
  end
  // All state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } ccsc_fifo_state_t;
  ccsc_fifo_state_t st_reg;
  ccsc_fifo_state_t st_next;
  logic push;
  logic pop;
  // Honest full and empty from the word count
  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) st_next.rptr = st_reg.rptr + 1'b1;
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  // State register, frozen while the enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_reg <= '0;
    else if (ce) st_reg <= st_next;
  end
endmodule : ccsc_fifo

// file: rtl/ccsc_selector.sv
// Camera channel selector with routing and throughput checker
// Summary of operation
// - Each serial receiver carries four virtual channels
// - Eight capture channels, numbered 0 to 7
// - Parallel port: two channels, clock up to 100 MHz
// - Quad A only to 0..3, VC0 to 0
// - One-quad variant: dual to 4..7, VC0 4
// - Two-quad variant: quad B to 4..7, VC0 4
// - Two-quad variant: dual VC0 to 0 or 4
// - Capture clock above 222.75 MHz is illegal
// - Fast quad A stream: channels 1..3 unused
// - Fast quad B stream: channels 5..7 unused
// - One-quad: fastest parallel/dual stream on 4
// - Two-quad: parallel used moves dual; else fastest 4
// - Per channel output rate at most 891 Mbyte/s
// - One-quad summed output at most 1336.5 Mbyte/s
// - Two-quad summed output at most 2227.5 Mbyte/s
module ccsc_selector #(
  parameter bit TWO_QUAD = 1'b1,
  parameter int FIFO_DEPTH = ccsc_pkg::CCSC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic cfg_valid,
  output logic cfg_ready,
  input wire ccsc_pkg::ccsc_table_t cfg_table,
  output logic cfg_accept,
  output logic cfg_reject,
  output logic [ccsc_pkg::CCSC_F_W-1:0] cfg_fault,
  output logic viol_flag,
  output logic ovf_flag,
  input wire logic viol_clear,
  output logic [ccsc_pkg::CCSC_NUM_CAP-1:0] cap_active,
  input wire logic pin_vclk,
  input wire logic pin_valid,
  input wire ccsc_pkg::ccsc_word_t pin_word,
  output logic stream_ready,
  output logic cap_valid,
  input wire logic cap_ready,
  output ccsc_pkg::ccsc_cap_t cap_out
);
  // ==========================================================
  // Parameter check
  // ==========================================================
  if (FIFO_DEPTH < 2) begin : g_bad
    $error("ccsc_selector: buffer depth below 2");
  end

  // All state of the selector
  typedef struct packed {
    logic [1:0] vclk_sync;               // [0] first stage
    logic vclk_last;                     // Previous second stage
    logic [1:0] val_sync;                // Valid synchroniser
    ccsc_pkg::ccsc_word_t [1:0] word_sync;  // Word synchroniser
    ccsc_pkg::ccsc_table_t table_q;      // Routing table in force
    logic viol;                          // Sticky violation flag
    logic ovf;                           // Sticky overflow flag
    logic accept;                        // Setting taken pulse
    logic reject;                        // Setting refused pulse
    logic [ccsc_pkg::CCSC_F_W-1:0] fault;  // Last checked faults
    logic cap_v;                         // Output word valid
    ccsc_pkg::ccsc_cap_t cap;            // Output word
  } ccsc_state_t;

  ccsc_state_t st_reg;
  ccsc_state_t st_next;

  logic vclk_rise;      // Rising edge of the sampled link clock
  logic push_req;       // Word captured on that edge
  logic fifo_in_ready;  // Buffer has room
  logic fifo_out_valid; // Buffer holds a word
  logic fifo_out_ready; // Output stage can take a word
  ccsc_pkg::ccsc_word_t fifo_word;  // Word at the buffer head
  logic [ccsc_pkg::CCSC_F_W-1:0] req_fault;  // Faults of request
  logic hit;            // Head word has a destination
  logic [2:0] hit_chan; // Destination capture channel

  // ==========================================================
  // Link clock edge and stream capture
  // ==========================================================
  // Edge found on second stage only, never the first
  assign vclk_rise = st_reg.vclk_sync[1] && !st_reg.vclk_last;
  assign push_req = vclk_rise && st_reg.val_sync[1];
  assign stream_ready = fifo_in_ready;

  // Stream buffer between link sampling and capture output
  ccsc_fifo #(
    .W($bits(ccsc_pkg::ccsc_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.word_sync[1]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_word)
  );

  // Head of buffer moves when the output stage is free
  assign fifo_out_ready = !st_reg.cap_v || cap_ready;

  // ==========================================================
  // Route lookup of the head word
  // ==========================================================
  always_comb begin
    hit = 1'b0;
    hit_chan = 3'h0;
    for (int i = 0; i < ccsc_pkg::CCSC_NUM_CAP; i++) begin
      if (!hit && st_reg.table_q[i].en
          && st_reg.table_q[i].src == fifo_word.src
          && st_reg.table_q[i].vc == fifo_word.vc) begin
        hit = 1'b1;
        hit_chan = 3'(i);
      end
    end
  end

  // ==========================================================
  // Checker on the requested setting
  // ==========================================================
  // Full routing and throughput check
  assign req_fault = ccsc_pkg::ccsc_check(cfg_table, TWO_QUAD);
  // Settings are taken whenever the block is enabled
  assign cfg_ready = ce;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    // Two flip-flops on every pin input
    st_next.vclk_sync = {st_reg.vclk_sync[0], pin_vclk};
    st_next.vclk_last = st_reg.vclk_sync[1];
    st_next.val_sync = {st_reg.val_sync[0], pin_valid};
    st_next.word_sync = {st_reg.word_sync[0], pin_word};
    st_next.accept = 1'b0;
    st_next.reject = 1'b0;
    // Software clear first, so a new event below wins
    if (viol_clear) begin
      st_next.viol = 1'b0;
      st_next.ovf = 1'b0;
    end
    // Word arriving with no room is lost and flagged
    if (vclk_rise && st_reg.val_sync[1] && !fifo_in_ready)
      st_next.ovf = 1'b1;
    if (cfg_valid) begin
      st_next.fault = req_fault;
      if (req_fault == '0) begin
        st_next.table_q = cfg_table;
        st_next.accept = 1'b1;
      end else begin
        st_next.viol = 1'b1;
        st_next.reject = 1'b1;
      end
    end
    // Output stage: load routed word, drop unrouted ones
    if (fifo_out_ready) begin
      st_next.cap_v = fifo_out_valid && hit;
      if (fifo_out_valid && hit) begin
        st_next.cap.chan = hit_chan;
        st_next.cap.data = fifo_word.data;
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_reg <= '0;
    else if (ce) st_reg <= st_next;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign cfg_accept = st_reg.accept;
  assign cfg_reject = st_reg.reject;
  assign cfg_fault = st_reg.fault;
  assign viol_flag = st_reg.viol;
  assign ovf_flag = st_reg.ovf;
  assign cap_valid = st_reg.cap_v;
  assign cap_out = st_reg.cap;

  // Enable bits of the table in force
  always_comb begin
    for (int i = 0; i < ccsc_pkg::CCSC_NUM_CAP; i++) begin
      cap_active[i] = st_reg.table_q[i].en;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  logic [ccsc_pkg::CCSC_F_W-1:0] live_fault;  // Faults of live table
  assign live_fault = ccsc_pkg::ccsc_check(st_reg.table_q, TWO_QUAD);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Refused setting raises flag and keeps the table
  property p_reject;
    ce && cfg_valid && req_fault != '0
      |=> viol_flag && cfg_reject && $stable(cap_active);
  endproperty
  a_reject: assert property (p_reject)
    else $error("refused setting did not flag or changed table");

  // Flag holds until cleared
  property p_sticky;
    viol_flag && !viol_clear |=> viol_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("violation flag dropped without clear");

  // Legal setting is installed in the next cycle
  property p_accept;
    ce && cfg_valid && req_fault == '0
      |=> cfg_accept && !cfg_reject && cfg_fault == '0;
  endproperty
  a_accept: assert property (p_accept)
    else $error("legal setting not accepted");

  // Live table never breaks routing ranges
  property p_range;
    !live_fault[ccsc_pkg::CCSC_F_RANGE] && !live_fault[ccsc_pkg::CCSC_F_VC0];
  endproperty
  a_range: assert property (p_range)
    else $error("table routes a receiver to a forbidden channel");

  // Live table keeps capture clocks in range
  property p_clk;
    !live_fault[ccsc_pkg::CCSC_F_CLK] && !live_fault[ccsc_pkg::CCSC_F_PAR];
  endproperty
  a_clk: assert property (p_clk)
    else $error("table holds an over-fast capture clock");

  // Live table keeps per channel output rate
  property p_out;
    !live_fault[ccsc_pkg::CCSC_F_OUT];
  endproperty
  a_out: assert property (p_out)
    else $error("table holds an over-rate channel");

  // Live table keeps the summed rate
  property p_sum;
    !live_fault[ccsc_pkg::CCSC_F_SUM];
  endproperty
  a_sum: assert property (p_sum)
    else $error("table exceeds the summed output rate");

  // Fast quad stream leaves neighbours unused
  property p_lone;
    !live_fault[ccsc_pkg::CCSC_F_LONE] && !live_fault[ccsc_pkg::CCSC_F_SEL];
  endproperty
  a_lone: assert property (p_lone)
    else $error("fast stream shares its group or is off channel 4");

  // Live table uses no receiver absent in this variant
  property p_var;
    !live_fault[ccsc_pkg::CCSC_F_VAR];
  endproperty
  a_var: assert property (p_var)
    else $error("table uses a receiver missing in this variant");

  // Stalled output word holds still
  property p_hold;
    ce && cap_valid && !cap_ready |=> cap_valid && $stable(cap_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output word changed while stalled");

  // Main scenarios
  c_accept: cover property (ce && cfg_valid ##1 cfg_accept);
  c_reject: cover property (ce && cfg_valid ##1 cfg_reject);
  c_chan4: cover property (cap_valid && cap_ready && cap_out.chan == 3'h4);
  c_full: cover property (!stream_ready);
  c_ovf: cover property (ovf_flag);
endmodule : ccsc_selector

// file: verif/ccsc_camera_model.sv
// Camera source model driving the parallel link pins of the selector
module ccsc_camera_model (
  output logic pin_vclk,
  output logic pin_valid,
  output ccsc_pkg::ccsc_word_t pin_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Idle state: link clock stands still low
  // ==========================================
  initial begin
    pin_vclk = 1'b0;
    pin_valid = 1'b0;
    pin_word = '0;
  end
  // ==========================================
  // One word per link clock period of 837 ns
  // ==========================================
  // bounded source rate
  task automatic send(input ccsc_pkg::ccsc_src_t s, input logic [1:0] v,
                      input logic [15:0] d);
    // Odd offset keeps the link phase unrelated to clk
    #37;
    pin_word = '{src: s, vc: v, data: d};
    pin_valid = 1'b1;
    #400 pin_vclk = 1'b1;
    #400 pin_vclk = 1'b0;
    // Released word lines show the inverse, not the old value
    pin_valid = 1'b0;
    pin_word = ~pin_word;
  endtask : send
endmodule : ccsc_camera_model

// file: verif/ccsc_selector_test.sv
// Self-checking bench of the channel selector and its checker
module ccsc_selector_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals and short source names
  // ==========================================
  localparam ccsc_pkg::ccsc_src_t QA = ccsc_pkg::CCSC_SRC_QUAD_A;
  localparam ccsc_pkg::ccsc_src_t QB = ccsc_pkg::CCSC_SRC_QUAD_B;
  localparam ccsc_pkg::ccsc_src_t DU = ccsc_pkg::CCSC_SRC_DUAL;
  localparam ccsc_pkg::ccsc_src_t PA = ccsc_pkg::CCSC_SRC_PAR;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic cfg_valid = 1'b0;
  logic cfg_ready, cfg_accept, cfg_reject, viol_flag, ovf_flag;
  ccsc_pkg::ccsc_table_t cfg_table = '0;
  logic [ccsc_pkg::CCSC_F_W-1:0] cfg_fault;
  logic viol_clear = 1'b0;
  logic [7:0] cap_active;
  logic pin_vclk, pin_valid, stream_ready, cap_valid;
  ccsc_pkg::ccsc_word_t pin_word;
  logic cap_ready = 1'b0;
  ccsc_pkg::ccsc_cap_t cap_out;
  int num_errors = 0;
  int samples_checked = 0;
  ccsc_pkg::ccsc_table_t t;
  logic one_acc;
  logic [ccsc_pkg::CCSC_F_W-1:0] one_fault;
  // 10 MHz clock
  always #50 clk = ~clk;
  // ==========================================
  // Design and camera model
  // ==========================================
  ccsc_selector #(.TWO_QUAD(1'b1), .FIFO_DEPTH(16)) dut_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_table(cfg_table), .cfg_accept(cfg_accept),
    .cfg_reject(cfg_reject), .cfg_fault(cfg_fault), .viol_flag(viol_flag),
    .ovf_flag(ovf_flag), .viol_clear(viol_clear), .cap_active(cap_active),
    .pin_vclk(pin_vclk), .pin_valid(pin_valid), .pin_word(pin_word),
    .stream_ready(stream_ready), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .cap_out(cap_out));
  ccsc_camera_model pm_u (.pin_vclk(pin_vclk), .pin_valid(pin_valid),
    .pin_word(pin_word));
  // One-quad variant
  ccsc_selector #(.TWO_QUAD(1'b0)) one_u (
    .clk(clk), .reset_n(reset_n), .ce(ce), .cfg_valid(cfg_valid),
    .cfg_ready(), .cfg_table(cfg_table), .cfg_accept(one_acc),
    .cfg_reject(), .cfg_fault(one_fault), .viol_flag(), .ovf_flag(),
    .viol_clear(viol_clear), .cap_active(), .pin_vclk(pin_vclk),
    .pin_valid(pin_valid), .pin_word(pin_word), .stream_ready(),
    .cap_valid(), .cap_ready(cap_ready), .cap_out());
  // ==========================================
  // Helpers
  // ==========================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Enabled entry of modest clock, unit scale, two bytes per pixel
  function automatic ccsc_pkg::ccsc_entry_t ent(input ccsc_pkg::ccsc_src_t s,
                                                input logic [1:0] v);
    ent = '{en: 1'b1, src: s, vc: v, vclk: 16'h0100, scale_q4: 8'h10,
            depth: 3'h2, in_rate: 16'h0100};
  endfunction : ent
  // Quad A channel 0 on capture 0, quad B channel 0 on capture 4
  function automatic ccsc_pkg::ccsc_table_t base();
    base = '0;
    base[0] = ent(QA, 2'h0);
    base[4] = ent(QB, 2'h0);
  endfunction : base
  // Request a table; fb < 0 expects acceptance, else that fault bit
  task automatic cfg(input ccsc_pkg::ccsc_table_t tb, input int fb,
                     input logic [7:0] act);
    int n;
    n = 0;
    @(negedge clk);
    cfg_table = tb;
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    while (!(cfg_accept === 1'b1 || cfg_reject === 1'b1) && n < 2) begin
      @(negedge clk);
      n++;
    end
    chk(cfg_accept, fb < 0, "accept pulse");
    chk(cfg_reject, fb >= 0, "reject pulse");
    if (fb < 0) chk(cfg_fault, 0, "fault bits set");
    else chk(cfg_fault[fb], 1, "fault bit missing");
    chk(cap_active, act, "active channels");
  endtask : cfg
  // Wait for a capture word, compare and take it
  task automatic take(input logic [2:0] ch, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cap_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(cap_valid, 1, "no capture word");
    chk(cap_out.chan, ch, "capture channel");
    chk(cap_out.data, d, "capture data");
    cap_ready = 1'b1;
    @(negedge clk);
    cap_ready = 1'b0;
  endtask : take
  // One-quad verdict on a table; fb < 0 expects acceptance
  task automatic one(input ccsc_pkg::ccsc_table_t tb, input int fb);
    @(negedge clk);
    cfg_table = tb;
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    chk(one_acc, fb < 0, "one-quad verdict");
    if (fb >= 0) chk(one_fault[fb], 1, "one-quad fault bit");
  endtask : one
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_route();
    t = base(); cfg(t, -1, 8'h11);
    t[5] = ent(QA, 2'h1); cfg(t, ccsc_pkg::CCSC_F_RANGE, 8'h11);
    chk(viol_flag, 1, "sticky flag");
    t = base(); t[3] = ent(QB, 2'h1); cfg(t, ccsc_pkg::CCSC_F_RANGE, 8'h11);
    t = base(); t[1] = ent(QA, 2'h0); cfg(t, ccsc_pkg::CCSC_F_VC0, 8'h11);
    t = base(); t[0] = ent(DU, 2'h0); cfg(t, -1, 8'h11);
    t = base(); t[2] = ent(DU, 2'h0); cfg(t, ccsc_pkg::CCSC_F_VC0, 8'h11);
    t = base(); t[5] = ent(QB, 2'h1); t[5].in_rate = 16'h0200;
    cfg(t, ccsc_pkg::CCSC_F_SEL, 8'h11);
    cfg(base(), -1, 8'h11);
    chk(viol_flag, 1, "flag kept after accept");
    viol_clear = 1'b1;
    @(negedge clk);
    viol_clear = 1'b0;
    chk(viol_flag, 0, "flag not cleared");
  endtask : t_route
  task automatic t_rates();
    t = base(); t[0].vclk = 16'h06f6; cfg(t, -1, 8'h11);
    t[0].vclk = 16'h06f7; cfg(t, ccsc_pkg::CCSC_F_CLK, 8'h11);
    t = base(); t[0].vclk = 16'h0591; t[0].depth = 3'h5;
    cfg(t, -1, 8'h11);
    t[0].vclk = 16'h0592; cfg(t, ccsc_pkg::CCSC_F_OUT, 8'h11);
    t = base(); t[1] = ent(QA, 2'h1);
    for (int i = 0; i < 2; i++) begin
      t[i*4].vclk = 16'h06f6;
      t[i*4].depth = 3'h4;
    end
    cfg(t, -1, 8'h13);
    t[1].vclk = 16'h06f6; t[1].depth = 3'h4;
    cfg(t, ccsc_pkg::CCSC_F_SUM, 8'h13);
    t = base(); t[0].in_rate = 16'h0dec; t[1] = ent(QA, 2'h1);
    cfg(t, -1, 8'h13);
    t[0].in_rate = 16'h0ded; cfg(t, ccsc_pkg::CCSC_F_LONE, 8'h13);
    t = base(); t[4].in_rate = 16'h0ded; t[5] = ent(QB, 2'h1);
    cfg(t, ccsc_pkg::CCSC_F_LONE, 8'h13);
  endtask : t_rates
  task automatic t_par();
    t = base(); t[1] = ent(PA, 2'h0); t[1].vclk = 16'h0320;
    cfg(t, -1, 8'h13);
    t[1].vclk = 16'h0321; cfg(t, ccsc_pkg::CCSC_F_PAR, 8'h13);
    t[1].vclk = 16'h0320; t[5] = ent(DU, 2'h1);
    cfg(t, ccsc_pkg::CCSC_F_RANGE, 8'h13);
    t[5].en = 1'b0; t[2] = ent(DU, 2'h1); cfg(t, -1, 8'h17);
  endtask : t_par
  task automatic t_stream();
    t = base(); t[6] = ent(DU, 2'h1);
    for (int v = 1; v < 4; v++) t[v] = ent(QA, 2'(v));
    cfg(t, -1, 8'h5f);
    for (int v = 0; v < 4; v++) begin
      pm_u.send(QA, 2'(v), 16'h1000 + 16'(v));
      take(3'(v), 16'h1000 + 16'(v));
    end
    pm_u.send(DU, 2'h3, 16'hdead);
    pm_u.send(QB, 2'h0, 16'h2222); take(3'h4, 16'h2222);
    pm_u.send(DU, 2'h1, 16'h3333); take(3'h6, 16'h3333);
  endtask : t_stream
  task automatic t_fill();
    int k;
    int n;
    for (int i = 0; i < 20; i++) pm_u.send(QA, 2'h0, 16'(i));
    repeat (6) @(negedge clk);
    chk(stream_ready, 0, "buffer not full");
    chk(ovf_flag, 1, "overflow flag");
    k = 0;
    n = 0;
    while (n < 20) begin
      @(negedge clk);
      n++;
      if (cap_valid === 1'b1) begin
        chk(cap_out.data, 16'(k), "drain order");
        cap_ready = 1'b1;
        @(negedge clk);
        cap_ready = 1'b0;
        k++;
        n = 0;
      end
    end
    chk(k, ccsc_pkg::CCSC_FIFO_DEPTH + 1, "words kept");
    chk(stream_ready, 1, "buffer not empty");
    viol_clear = 1'b1;
    @(negedge clk);
    viol_clear = 1'b0;
    chk(ovf_flag, 0, "overflow not cleared");
  endtask : t_fill
  task automatic t_ce();
    @(negedge clk);
    ce = 1'b0;
    cfg_table = '0;
    cfg_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk(cfg_ready, 0, "ready with ce low");
    chk(cfg_accept | cfg_reject, 0, "taken with ce low");
    chk(cap_active, 8'h5f, "table changed with ce low");
    ce = 1'b1;
    cfg_valid = 1'b0;
  endtask : t_ce
  // One-quad variant checks
  task automatic t_one();
    t = '0; t[4] = ent(DU, 2'h0); t[5] = ent(PA, 2'h1);
    t[5].in_rate = 16'h0080; one(t, -1);
    t[5].in_rate = 16'h0200; one(t, ccsc_pkg::CCSC_F_SEL);
    t[1] = ent(DU, 2'h1); one(t, ccsc_pkg::CCSC_F_RANGE);
    t[1] = ent(QB, 2'h1); one(t, ccsc_pkg::CCSC_F_VAR);
    t = '0; t[0] = ent(QA, 2'h0); t[0].vclk = 16'h06f6; t[0].depth = 3'h3;
    t[4] = t[0]; t[4].src = DU; one(t, -1);
    t[4].depth = 3'h4; one(t, ccsc_pkg::CCSC_F_SUM);
  endtask : t_one
  // ==========================================
  // Verdict
  // ==========================================
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    chk(cap_active, 0, "active after reset");
    chk(stream_ready, 1, "ready after reset");
    t_route();
    t_rates();
    t_par();
    t_stream();
    t_ce();
    t_fill();
    t_one();
    end_of_test();
  end
  // Watchdog well past the expected run time
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule : ccsc_selector_test
